// ---- logic/xbus_decode_config.sv ----
/*
  Configuration registers over APB and the X-Bus address decode they steer:
  boot ROM select, floppy, IDE, keyboard and RTC selects, transceiver enable,
  page address, interrupt routing bits and bus clock divisor.
  Assumes cycle pins hold steady while a strobe is active; every pin is resynchronised.
*/
// The APB register port was decided locally.
// Summary of operation
// - Test low floats all outputs
// - Stepping byte is fixed, writes ignored
// - Mode bit 5 drives RAM page address
// - Mode bit 4 picks separate or encoded selects
// - Mode bit 3 gates NMI on system error
// - Mode bits 1:0 zero select discrete masters
// - ROM select on reads; writes need enable
// - Bit 5 enables enlarged top ROM window
// - Bit 4 enables high ROM segment aliases
// - Bits 0-3 enable four low ROM blocks
// - Bit 2 enables top 64K below 16M
// - Bits 0,1 enable video ROM blocks
// - Bit 5 routes coprocessor error to IRQ13
// - Bit 4 makes mouse edge raise IRQ12
// - Divisor code 000 by 4, 001 by 3
// - Disabled peripheral gets no select, no transceiver
// - Bit 5 picks primary or secondary ports
// - Floppy select needs strap plus pair or rest bit for the port
// - Reset enables rest ports, disables floppy pair
// - Shared status ports go to IDE select when bit 4 enables IDE decode, else to floppy
// - Disk change strap caught after reset
// - Bit 4 enables IDE decode
// - Bit 1 enables keyboard decode
`timescale 1ns/10ps
module xbus_decode_config
  import xbus_cfg_pkg::*;
#(
  parameter logic [7:0] STEPPING_CODE = 8'h5a // Arbitrary value
)(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pins from the system side
  input wire logic TEST_N,
  input wire logic [31:0] LA,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic [7:0] IO_DATA,
  input wire logic SERR_N,
  input wire logic FPU_ERROR_N,
  input wire logic AUX_BUFFER_FULL,
  input wire logic DISK_CHANGE_IN,
  // Output enable shared by all output pins
  output logic PIN_OE_N,
  // Chip selects and transceiver
  output logic ROM_CHIP_SELECT_N,
  output logic FLOPPY_CHIP_SELECT_N,
  output logic IDE_CHIP_SELECT0_N,
  output logic IDE_CHIP_SELECT1_N,
  output logic KBD_CHIP_SELECT_N,
  output logic RTC_CHIP_SELECT_N,
  output logic XBUS_OUTPUT_ENABLE_N,
  output logic [2:0] SHARED_CHIP_SELECT,
  // Page address and pin modes
  output logic [4:0] CRAM_PAGE_ADDRESS,
  output logic CRAM_PAGE_DRIVE,
  output logic MASTER_DISCRETE_MODE,
  // Interrupt requests and bus clock
  output logic NMI_PULSE,
  output logic IRQ13_REQ,
  output logic IRQ12_REQ,
  output logic BUS_CLK,
  output logic BUS_CLK_STROBE
);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  function automatic logic io_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] span);
    io_win = (a >= lo) && (a <= lo + span);
  endfunction : io_win

  pins_type pins_in;
  pins_type sync1_r;
  pins_type s;
  logic [7:0] mode_r;
  logic [7:0] rom_a_r;
  logic [7:0] rom_b_r;
  logic [7:0] bus_clock_divider_r;
  logic [7:0] periph_r;
  logic [4:0] cram_page_r;
  logic strap_r;
  logic [1:0] strap_cnt_r;
  logic serr_prev_r;
  logic aux_prev_r;
  logic hit;
  logic [7:0] rd_mux;
  logic wr_take;

  assign pins_in = '{test_n: TEST_N, la: LA, mem_rd: MEM_RD, mem_wr: MEM_WR, io_rd: IO_RD, io_wr: IO_WR,
    io_data: IO_DATA, serr_n: SERR_N, fpu_error_n: FPU_ERROR_N, aux_buffer_full: AUX_BUFFER_FULL,
    disk_change: DISK_CHANGE_IN};

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_r <= PINS_RST;
      s <= PINS_RST;
    end else begin
      sync1_r <= pins_in;
      s <= sync1_r;
    end
  end

  // Register decode and read data
  always_comb begin
    hit = 1'b1;
    rd_mux = 8'h00;
    unique case (PADDR[11:2])
      IDX_STEPPING: rd_mux = STEPPING_CODE;
      IDX_MODE: rd_mux = mode_r;
      IDX_ROM_A: rd_mux = rom_a_r;
      IDX_ROM_B: rd_mux = rom_b_r;
      IDX_BUS_CLOCK_DIVIDER: rd_mux = bus_clock_divider_r;
      IDX_PERIPH: rd_mux = periph_r;
      default: hit = 1'b0;
    endcase
  end

  // Answer in the first access cycle; unmapped addresses error
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= {24'h0, rd_mux};
      end
    end
  end

  assign wr_take = PSEL && PENABLE && PREADY && PWRITE;

  // Writable registers; stepping index has no storage, reserved bits masked
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_r <= MODE_RST;
      rom_a_r <= ROM_A_RST;
      rom_b_r <= ROM_B_RST;
      bus_clock_divider_r <= BUS_CLOCK_DIVIDER_RST;
      periph_r <= PERIPH_RST;
    end else if (wr_take) begin
      unique case (PADDR[11:2])
        IDX_MODE: mode_r <= PWDATA[7:0] & MODE_MASK;
        IDX_ROM_A: rom_a_r <= PWDATA[7:0] & ROM_A_MASK;
        IDX_ROM_B: rom_b_r <= PWDATA[7:0] & ROM_B_MASK;
        IDX_BUS_CLOCK_DIVIDER: bus_clock_divider_r <= PWDATA[7:0] & BUS_CLOCK_DIVIDER_MASK;
        IDX_PERIPH: periph_r <= PWDATA[7:0] & PERIPH_MASK;
        default: ;
      endcase
    end
  end

  property p_stepping_ro;
    (PSEL && !PENABLE && !PWRITE && PADDR[11:2] == IDX_STEPPING) |=> PRDATA == {24'h0, STEPPING_CODE};
  endproperty
  a_stepping_ro: assert property (p_stepping_ro) else $error("stepping byte read wrong");

  property p_reserved_zero;
    (PSEL && !PENABLE && !PWRITE && PADDR[11:2] == IDX_BUS_CLOCK_DIVIDER) |=> (PRDATA[7:0] & ~BUS_CLOCK_DIVIDER_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  // Floppy strap caught once the synchroniser has filled after reset release
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_cnt_r <= 2'h0;
      strap_r <= 1'b0;
    end else if (strap_cnt_r != STRAP_WAIT + 2'h1) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_WAIT) begin
        strap_r <= s.disk_change;
      end
    end
  end

  // Decode of the current cycle
  logic io_cyc;
  logic [15:0] ia;
  logic sec;
  logic rom_hit;
  logic rom_sel;
  logic ide0;
  logic ide1;
  logic shared;
  logic flp;
  logic flp_oe;
  logic kbd;
  logic rtc;
  logic cram;
  logic [3:0] low_hit;

  assign io_cyc = s.io_rd || s.io_wr;
  assign ia = s.la[15:0];
  assign sec = periph_r[PER_SECONDARY_BIT];

  // Low ROM blocks and their two high aliases
  always_comb begin
    low_hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      low_hit[i] = rom_a_r[i] && (in_win(s.la, LOW_ROM_BASE + BLOCK16K_SIZE * i,
          LOW_ROM_BASE + BLOCK16K_SIZE * (i + 1) - 32'h1)
        || in_win(s.la, LOW_ALIAS1_BASE + BLOCK16K_SIZE * i, LOW_ALIAS1_BASE + BLOCK16K_SIZE * (i + 1) - 32'h1)
        || in_win(s.la, LOW_ALIAS2_BASE + BLOCK16K_SIZE * i,
          LOW_ALIAS2_BASE + BLOCK16K_SIZE * (i + 1) - 32'h1));
    end
  end

  assign rom_hit = (|low_hit)
    || (rom_a_r[ROM_A_ENLARGED_BIT] && in_win(s.la, ENLARGED_LO, ENLARGED_HI))
    || (rom_a_r[ROM_A_HIGH_BIT] && (in_win(s.la, HIGH_ROM_BASE, HIGH_ROM_BASE + SEG64K_LAST)
      || in_win(s.la, ROM_16M_BASE, ROM_16M_BASE + SEG64K_LAST)
      || in_win(s.la, ROM_4G_BASE, ROM_4G_BASE + SEG64K_LAST)))
    || (rom_b_r[ROM_B_16M_BIT] && in_win(s.la, ROM_16M_BASE, ROM_16M_BASE + SEG64K_LAST))
    || (rom_b_r[ROM_B_VGA_LO_BIT] && in_win(s.la, VGA_LO_BASE, VGA_LO_BASE + BLOCK16K_SIZE - 32'h1))
    || (rom_b_r[ROM_B_VGA_HI_BIT] && in_win(s.la, VGA_HI_BASE, VGA_HI_BASE + BLOCK16K_SIZE - 32'h1));

  // Writes reach the ROM only with the write enable set
  assign rom_sel = rom_hit && (s.mem_rd || (s.mem_wr && rom_b_r[ROM_B_WRITE_BIT]));

  assign shared = io_win(ia, sec ? SHARED_S : SHARED_P, PAIR_SPAN);
  assign ide0 = io_cyc && periph_r[PER_IDE_BIT] && io_win(ia, sec ? IDE_TASK_S : IDE_TASK_P, TASK_SPAN);
  assign ide1 = io_cyc && periph_r[PER_IDE_BIT] && shared;
  // Shared status ports never reach the floppy while IDE owns them
  assign flp = io_cyc && strap_r && !ide1
    && ((periph_r[PER_FLP_PAIR_BIT] && io_win(ia, sec ? FLP_PAIR_S : FLP_PAIR_P, PAIR_SPAN))
    || (periph_r[PER_FLP_REST_BIT] && in_win({16'h0, ia}, {16'h0, sec ? FLP_REST_S : FLP_REST_P},
      {16'h0, sec ? FLP_REST_S_END : FLP_REST_P_END})));
  // No transceiver on a disk-status read when no IDE sits on the X-Bus
  assign flp_oe = flp && !(s.io_rd && !periph_r[PER_IDE_BIT] && ia == (sec ? DISK_STAT_S : DISK_STAT_P));
  assign kbd = io_cyc && periph_r[PER_KBD_BIT] && io_win(ia, KBD_FIRST, KBD_LAST - KBD_FIRST) && !ia[0];
  assign rtc = io_cyc && periph_r[PER_RTC_BIT] && io_win(ia, RTC_FIRST, RTC_LAST - RTC_FIRST);
  assign cram = io_cyc && io_win(ia, CRAM_FIRST, CRAM_LAST - CRAM_FIRST);

  // Registered chip selects and transceiver enable
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ROM_CHIP_SELECT_N <= 1'b1;
      FLOPPY_CHIP_SELECT_N <= 1'b1;
      IDE_CHIP_SELECT0_N <= 1'b1;
      IDE_CHIP_SELECT1_N <= 1'b1;
      KBD_CHIP_SELECT_N <= 1'b1;
      RTC_CHIP_SELECT_N <= 1'b1;
      XBUS_OUTPUT_ENABLE_N <= 1'b1;
    end else begin
      ROM_CHIP_SELECT_N <= !rom_sel;
      FLOPPY_CHIP_SELECT_N <= !flp;
      IDE_CHIP_SELECT0_N <= !ide0;
      IDE_CHIP_SELECT1_N <= !ide1;
      KBD_CHIP_SELECT_N <= !kbd;
      RTC_CHIP_SELECT_N <= !rtc;
      XBUS_OUTPUT_ENABLE_N <= !(rom_sel || flp_oe || ide0 || ide1 || kbd || rtc);
    end
  end

  // Shared pins: separate selects idle here, encoded mode carries the IDE selects
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SHARED_CHIP_SELECT <= CS_PINS_IDLE;
    end else if (!mode_r[MODE_ENC_CS_BIT]) begin
      SHARED_CHIP_SELECT <= CS_PINS_IDLE;
    end else begin
      SHARED_CHIP_SELECT <= ide0 ? ENC_IDE0 : (ide1 ? ENC_IDE1 : CS_PINS_IDLE);
    end
  end

  // Page number latched from the page port; driven only during RAM space access
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cram_page_r <= 5'h00;
      CRAM_PAGE_ADDRESS <= 5'h00;
      CRAM_PAGE_DRIVE <= 1'b0;
    end else begin
      if (s.io_wr && ia == CRAM_PAGE_PORT) begin
        cram_page_r <= s.io_data[4:0];
      end
      CRAM_PAGE_DRIVE <= cram && mode_r[MODE_CRAM_BIT];
      CRAM_PAGE_ADDRESS <= (cram && mode_r[MODE_CRAM_BIT]) ? cram_page_r : 5'h00;
    end
  end

  // Pin modes and test float; test input stalls nothing else
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PIN_OE_N <= 1'b1;
      MASTER_DISCRETE_MODE <= 1'b1;
    end else begin
      PIN_OE_N <= !s.test_n;
      MASTER_DISCRETE_MODE <= (mode_r[1:0] == 2'b00);
    end
  end

  // Interrupt sources; set beats the port 60h read that clears the mouse latch
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      serr_prev_r <= 1'b1;
      aux_prev_r <= 1'b0;
      NMI_PULSE <= 1'b0;
      IRQ13_REQ <= 1'b0;
      IRQ12_REQ <= 1'b0;
    end else begin
      serr_prev_r <= s.serr_n;
      aux_prev_r <= s.aux_buffer_full;
      NMI_PULSE <= mode_r[MODE_NMI_BIT] && serr_prev_r && !s.serr_n;
      IRQ13_REQ <= bus_clock_divider_r[CLK_FPU_BIT] && !s.fpu_error_n;
      if (bus_clock_divider_r[CLK_MOUSE_BIT] && s.aux_buffer_full && !aux_prev_r) begin
        IRQ12_REQ <= 1'b1;
      end else if (s.io_rd && ia == KBD_FIRST) begin
        IRQ12_REQ <= 1'b0;
      end
    end
  end

  // Bus clock divider
  bus_clock_if bclk_link ();

  assign bclk_link.div_code = bus_clock_divider_r[2:0];
  assign BUS_CLK = bclk_link.bclk;
  assign BUS_CLK_STROBE = bclk_link.bclk_rise;

  bus_clock_gen u_bus_clock_gen (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .bus(bclk_link.gen)
  );

  property p_test_float;
    !s.test_n |=> PIN_OE_N;
  endproperty
  a_test_float: assert property (p_test_float) else $error("pins driven in test");

  property p_cram_off;
    !mode_r[MODE_CRAM_BIT] |=> !CRAM_PAGE_DRIVE && CRAM_PAGE_ADDRESS == 5'h00;
  endproperty
  a_cram_off: assert property (p_cram_off) else $error("page address driven while disabled");

  property p_separate_idle;
    !mode_r[MODE_ENC_CS_BIT] |=> SHARED_CHIP_SELECT == CS_PINS_IDLE;
  endproperty
  a_separate_idle: assert property (p_separate_idle) else $error("shared pins active");

  property p_nmi_gate;
    NMI_PULSE |-> $past(mode_r[MODE_NMI_BIT]) && $past(s.serr_n, 2) && !$past(s.serr_n);
  endproperty
  a_nmi_gate: assert property (p_nmi_gate) else $error("NMI without enabled error edge");

  property p_rom_write_gate;
    (s.mem_wr && !s.mem_rd && !rom_b_r[ROM_B_WRITE_BIT]) |=> ROM_CHIP_SELECT_N;
  endproperty
  a_rom_write_gate: assert property (p_rom_write_gate) else $error("ROM select on blocked write");

  property p_fpu_ignored;
    !bus_clock_divider_r[CLK_FPU_BIT] |=> !IRQ13_REQ;
  endproperty
  a_fpu_ignored: assert property (p_fpu_ignored) else $error("IRQ13 while routing off");

  property p_no_strap;
    !strap_r |=> FLOPPY_CHIP_SELECT_N;
  endproperty
  a_no_strap: assert property (p_no_strap) else $error("floppy select without strap");

  property p_shared_to_ide;
    (io_cyc && periph_r[PER_IDE_BIT] && shared) |=> !IDE_CHIP_SELECT1_N && FLOPPY_CHIP_SELECT_N;
  endproperty
  a_shared_to_ide: assert property (p_shared_to_ide) else $error("shared port not on IDE select");

  property p_kbd_off;
    !periph_r[PER_KBD_BIT] |=> KBD_CHIP_SELECT_N;
  endproperty
  a_kbd_off: assert property (p_kbd_off) else $error("keyboard select while disabled");

endmodule : xbus_decode_config

// ---- logic/xbus_cfg_pkg.sv ----
/*
  Constants, register map and pin bundle for the X-Bus decode configuration block.
  Assumes an APB master with 32-bit data; each register sits at four times its index.
*/
package xbus_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STEPPING = 10'h008;
  localparam logic [9:0] IDX_MODE = 10'h040;
  localparam logic [9:0] IDX_ROM_A = 10'h042;
  localparam logic [9:0] IDX_ROM_B = 10'h043;
  localparam logic [9:0] IDX_BUS_CLOCK_DIVIDER = 10'h04d;
  localparam logic [9:0] IDX_PERIPH = 10'h04e;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h20;
  localparam logic [7:0] ROM_A_RST = 8'h10;
  localparam logic [7:0] ROM_B_RST = 8'h00;
  localparam logic [7:0] BUS_CLOCK_DIVIDER_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h07;

  // Implemented bits; reserved bits stay zero
  localparam logic [7:0] MODE_MASK = 8'h3b;
  localparam logic [7:0] ROM_A_MASK = 8'h3f;
  localparam logic [7:0] ROM_B_MASK = 8'h0f;
  localparam logic [7:0] BUS_CLOCK_DIVIDER_MASK = 8'h37;
  localparam logic [7:0] PERIPH_MASK = 8'h3f;

  // Field positions
  localparam int MODE_CRAM_BIT = 5;
  localparam int MODE_ENC_CS_BIT = 4;
  localparam int MODE_NMI_BIT = 3;
  localparam int ROM_A_ENLARGED_BIT = 5;
  localparam int ROM_A_HIGH_BIT = 4;
  localparam int ROM_B_WRITE_BIT = 3;
  localparam int ROM_B_16M_BIT = 2;
  localparam int ROM_B_VGA_HI_BIT = 1;
  localparam int ROM_B_VGA_LO_BIT = 0;
  localparam int CLK_FPU_BIT = 5;
  localparam int CLK_MOUSE_BIT = 4;
  localparam int PER_SECONDARY_BIT = 5;
  localparam int PER_IDE_BIT = 4;
  localparam int PER_FLP_PAIR_BIT = 3;
  localparam int PER_FLP_REST_BIT = 2;
  localparam int PER_KBD_BIT = 1;
  localparam int PER_RTC_BIT = 0;

  // Bus clock divisor codes
  localparam logic [2:0] DIV_CODE_4 = 3'h0;
  localparam logic [2:0] DIV_CODE_3 = 3'h1;
  localparam logic [2:0] DIV_LAST_4 = 3'h3;
  localparam logic [2:0] DIV_LAST_3 = 3'h2;
  localparam logic [2:0] BCLK_HIGH_CNT = 3'h2;

  // Memory windows of the boot ROM
  localparam logic [31:0] LOW_ROM_BASE = 32'h000e0000;
  localparam logic [31:0] LOW_ALIAS1_BASE = 32'hffee0000;
  localparam logic [31:0] LOW_ALIAS2_BASE = 32'hfffe0000;
  localparam logic [31:0] BLOCK16K_SIZE = 32'h00004000;
  localparam logic [31:0] HIGH_ROM_BASE = 32'h000f0000;
  localparam logic [31:0] ROM_16M_BASE = 32'h00ff0000;
  localparam logic [31:0] ROM_4G_BASE = 32'hffff0000;
  localparam logic [31:0] SEG64K_LAST = 32'h0000ffff;
  localparam logic [31:0] ENLARGED_LO = 32'hfff80000;
  localparam logic [31:0] ENLARGED_HI = 32'hfffdffff;
  localparam logic [31:0] VGA_LO_BASE = 32'h000c0000;
  localparam logic [31:0] VGA_HI_BASE = 32'h000c4000;

  // I/O ports, primary and secondary
  localparam logic [15:0] FLP_PAIR_P = 16'h03f0;
  localparam logic [15:0] FLP_PAIR_S = 16'h0370;
  localparam logic [15:0] FLP_REST_P = 16'h03f2;
  localparam logic [15:0] FLP_REST_S = 16'h0372;
  localparam logic [15:0] FLP_REST_P_END = 16'h03f7;
  localparam logic [15:0] FLP_REST_S_END = 16'h037f;
  localparam logic [15:0] SHARED_P = 16'h03f6;
  localparam logic [15:0] SHARED_S = 16'h0376;
  localparam logic [15:0] DISK_STAT_P = 16'h03f7;
  localparam logic [15:0] DISK_STAT_S = 16'h0377;
  localparam logic [15:0] IDE_TASK_P = 16'h01f0;
  localparam logic [15:0] IDE_TASK_S = 16'h0170;
  localparam logic [15:0] PAIR_SPAN = 16'h0001;
  localparam logic [15:0] TASK_SPAN = 16'h0007;
  localparam logic [15:0] KBD_FIRST = 16'h0060;
  localparam logic [15:0] KBD_LAST = 16'h0066;
  localparam logic [15:0] RTC_FIRST = 16'h0070;
  localparam logic [15:0] RTC_LAST = 16'h0077;
  localparam logic [15:0] CRAM_FIRST = 16'h0800;
  localparam logic [15:0] CRAM_LAST = 16'h08ff;
  localparam logic [15:0] CRAM_PAGE_PORT = 16'h0c00;

  // Shared chip-select pin codes
  localparam logic [2:0] CS_PINS_IDLE = 3'h7;
  localparam logic [2:0] ENC_IDE0 = 3'h3;
  localparam logic [2:0] ENC_IDE1 = 3'h4;

  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic test_n;
    logic [31:0] la;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic [7:0] io_data;
    logic serr_n;
    logic fpu_error_n;
    logic aux_buffer_full;
    logic disk_change;
  } pins_type;

  localparam pins_type PINS_RST = '{test_n: 1'b1, la: 32'h0, mem_rd: 1'b0, mem_wr: 1'b0, io_rd: 1'b0,
    io_wr: 1'b0, io_data: 8'h0, serr_n: 1'b1, fpu_error_n: 1'b1, aux_buffer_full: 1'b0, disk_change: 1'b0};

endpackage : xbus_cfg_pkg

// ---- logic/bus_clock_if.sv ----
/*
  Link between the configuration core and the bus clock generator.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/10ps
interface bus_clock_if;
  logic [2:0] div_code;
  logic bclk;
  logic bclk_rise;

  modport ctl (output div_code, input bclk, input bclk_rise);
  modport gen (input div_code, output bclk, output bclk_rise);
endinterface : bus_clock_if

// ---- logic/bus_clock_gen.sv ----
/*
  Bus clock divider: makes the expansion bus clock and a one-cycle rise strobe.
  Assumes the divisor code comes from a register on the same clock.
*/
`timescale 1ns/10ps
module bus_clock_gen
  import xbus_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Divisor in, clock out
  bus_clock_if.gen bus
);

  logic [2:0] cnt_r;
  logic [2:0] last;

  // Reserved codes fall back to divide by four
  assign last = (bus.div_code == DIV_CODE_3) ? DIV_LAST_3 : DIV_LAST_4;

  // Counter wraps at or above the last count, so a change of divisor never strands it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 3'h0;
      bus.bclk <= 1'b0;
      bus.bclk_rise <= 1'b0;
    end else begin
      cnt_r <= (cnt_r >= last) ? 3'h0 : cnt_r + 3'h1;
      bus.bclk_rise <= (cnt_r >= last);
      bus.bclk <= (cnt_r >= last) || (cnt_r + 3'h1 < BCLK_HIGH_CNT);
    end
  end

  property p_div3_period;
    @(posedge clk) disable iff (!arst_n)
    (bus.bclk_rise && bus.div_code == DIV_CODE_3) ##1 (bus.div_code == DIV_CODE_3) ##1
      (bus.div_code == DIV_CODE_3) |=> bus.bclk_rise;
  endproperty
  a_div3_period: assert property (p_div3_period) else $error("divide by three period wrong");

  property p_div4_period;
    @(posedge clk) disable iff (!arst_n)
    (bus.bclk_rise && bus.div_code == DIV_CODE_4) ##1 (bus.div_code == DIV_CODE_4) [*2] |->
      !bus.bclk_rise && !$past(bus.bclk_rise) ##1 !bus.bclk_rise;
  endproperty
  a_div4_period: assert property (p_div4_period) else $error("divide by four strobe too early");

endmodule : bus_clock_gen

// ---- tb/xbus_far_model.sv ----
/*
  Far side of the X-Bus: the board strap that reports a fitted floppy controller.
  Assumes the strap is steady before reset is released and never changes after.
*/
`timescale 1ns/10ps
module xbus_far_model (
  // Board strap
  output logic disk_change
);
  // Strapped high: a floppy controller sits on the X-Bus
  assign disk_change = 1'b1;
endmodule : xbus_far_model

// ---- tb/tb_xbus_decode_config.sv ----
/*
  Bench for the X-Bus decode configuration block: APB register tasks and decode cycles.
  Assumes zero-wait APB answers and selects that settle three edges after the cycle pins.
*/
`timescale 1ns/10ps
module tb_xbus_decode_config
  import xbus_cfg_pkg::*;
;
  localparam logic [7:0] STEP = 8'h3c; // Arbitrary stepping value
  localparam logic [3:0] MR = 4'h8, MW = 4'h4, IR = 4'h2, IW = 4'h1;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, test_n, fpu_n, dsk, oe_n, mdisc, irq13, err;
  logic rom_n, flp_n, ide0_n, ide1_n, kbd_n, rtc_n, xoe_n;
  logic serr_n, aux, nmi, irq12, cdrv, bstb, bclk;
  logic [2:0] shcs;
  logic [4:0] cpg;
  logic [7:0] iod;
  logic [3:0] kind;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, la, rd;
  int err_count, n_compared;

  xbus_decode_config #(.STEPPING_CODE(STEP)) dut (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TEST_N(test_n), .LA(la), .MEM_RD(kind[3]), .MEM_WR(kind[2]), .IO_RD(kind[1]),
    .IO_WR(kind[0]), .IO_DATA(iod), .SERR_N(serr_n), .FPU_ERROR_N(fpu_n), .AUX_BUFFER_FULL(aux),
    .DISK_CHANGE_IN(dsk), .PIN_OE_N(oe_n), .ROM_CHIP_SELECT_N(rom_n), .FLOPPY_CHIP_SELECT_N(flp_n),
    .IDE_CHIP_SELECT0_N(ide0_n), .IDE_CHIP_SELECT1_N(ide1_n), .KBD_CHIP_SELECT_N(kbd_n),
    .RTC_CHIP_SELECT_N(rtc_n), .XBUS_OUTPUT_ENABLE_N(xoe_n), .SHARED_CHIP_SELECT(shcs), .CRAM_PAGE_ADDRESS(cpg),
    .CRAM_PAGE_DRIVE(cdrv), .MASTER_DISCRETE_MODE(mdisc), .NMI_PULSE(nmi), .IRQ13_REQ(irq13), .IRQ12_REQ(irq12),
    .BUS_CLK(bclk), .BUS_CLK_STROBE(bstb));
  xbus_far_model far (.disk_change(dsk));

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // One APB transfer; entered just after an edge, leaves one idle edge behind
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check($sformatf("reg %h", idx), rd, exp);
  endtask : rchk

  // Idle, then one cycle held long enough for the selects to settle
  task automatic cyc(input logic [31:0] a, input logic [3:0] k, input logic [5:0] exp);
    kind <= 4'h0;
    repeat (4) @(posedge clk);
    la <= a;
    kind <= k;
    repeat (4) @(posedge clk);
    check($sformatf("selects at %h", a), {rom_n, flp_n, ide0_n, ide1_n, kbd_n, rtc_n, xoe_n}, {exp, &exp});
  endtask : cyc

  // Strobes and high cycles of the bus clock over twelve system clocks
  task automatic strobes(input int exp, input int hi);
    int n, h;
    n = 0;
    h = 0;
    repeat (12) begin
      @(posedge clk);
      n += bstb;
      h += bclk;
    end
    check("bus clock strobes", n, exp);
    check("bus clock high", h, hi);
  endtask : strobes

  // Main sequence
  initial begin
    {psel, penable, pwrite, test_n, fpu_n, arst_n, serr_n, aux} = 8'b00011010;
    kind = 4'h0;
    iod = 8'h15;
    la = 32'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk(IDX_MODE, 32'h20);
    rchk(IDX_ROM_A, 32'h10);
    rchk(IDX_ROM_B, 32'h00);
    rchk(IDX_BUS_CLOCK_DIVIDER, 32'h00);
    rchk(IDX_PERIPH, 32'h07);
    apb(1'b1, IDX_STEPPING, 8'hff);
    rchk(IDX_STEPPING, {24'h0, STEP});
    apb(1'b1, IDX_MODE, 8'hff);
    rchk(IDX_MODE, 32'h3b);
    check("discrete mode", mdisc, 1'b0);
    rchk(10'h3ff, 32'h0);
    check("unmapped error", err, 1'b1);
    $display("register test done");
    // Boot ROM windows, reads and writes
    cyc(32'h000f0000, MR, 6'h1f);
    cyc(32'h000f0000, MW, 6'h3f);
    cyc(32'h000e0000, MR, 6'h3f);
    cyc(32'hfff80000, MR, 6'h3f);
    apb(1'b1, IDX_ROM_A, 8'h21);
    apb(1'b1, IDX_ROM_B, 8'h0d);
    cyc(32'h000e0000, MW, 6'h1f);
    cyc(32'hfff80000, MR, 6'h1f);
    cyc(32'h00ff0000, MR, 6'h1f);
    cyc(32'h000c0000, MR, 6'h1f);
    cyc(32'h000c4000, MR, 6'h3f);
    $display("rom test done");
    // Floppy, IDE and keyboard decode
    cyc(32'h000003f0, IR, 6'h3f);
    cyc(32'h000003f2, IR, 6'h2f);
    apb(1'b1, IDX_PERIPH, 8'h1f);
    cyc(32'h000003f0, IR, 6'h2f);
    cyc(32'h000003f6, IR, 6'h3b);
    cyc(32'h000001f0, IR, 6'h37);
    apb(1'b1, IDX_PERIPH, 8'h2d);
    cyc(32'h00000372, IR, 6'h2f);
    cyc(32'h000003f2, IR, 6'h3f);
    cyc(32'h00000170, IR, 6'h3f);
    cyc(32'h00000060, IR, 6'h3f);
    cyc(32'h00000070, IR, 6'h3e);
    $display("decode test done");
    // Encoded selects, page address and system error
    apb(1'b1, IDX_PERIPH, 8'h10);
    cyc(32'h000001f0, IR, 6'h37);
    check("encoded", shcs, ENC_IDE0);
    apb(1'b1, IDX_MODE, 8'h28);
    @(posedge clk);
    check("separate", shcs, CS_PINS_IDLE);
    check("discrete mode on", mdisc, 1'b1);
    cyc(32'h00000c00, IW, 6'h3f);
    cyc(32'h00000800, IR, 6'h3f);
    check("page", {cdrv, cpg}, 6'h35);
    apb(1'b1, IDX_MODE, 8'h08);
    @(posedge clk);
    check("page off", {cdrv, cpg}, 6'h00);
    serr_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("nmi", nmi, 1'b1);
    @(posedge clk);
    check("nmi pulse", nmi, 1'b0);
    $display("mode test done");
    // Coprocessor error routing and test float
    kind <= 4'h0;
    fpu_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("irq13 off", irq13, 1'b0);
    strobes(4'd3, 4'd6);
    apb(1'b1, IDX_BUS_CLOCK_DIVIDER, 8'h20);
    repeat (3) @(posedge clk);
    check("irq13 on", irq13, 1'b1);
    apb(1'b1, IDX_BUS_CLOCK_DIVIDER, 8'h31);
    aux <= 1'b1;
    repeat (4) @(posedge clk);
    check("irq12 set", irq12, 1'b1);
    strobes(4'd4, 4'd8);
    cyc(32'h00000060, IR, 6'h3f);
    check("irq12 clear", irq12, 1'b0);
    check("drive", oe_n, 1'b0);
    test_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("float", oe_n, 1'b1);
    $display("pin test done");
    give_verdict();
  end
endmodule : tb_xbus_decode_config
